// ---- hdl/dsr_status_regs.sv ----
// Design decision made here: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module dsr_status_regs
(
    input  wire logic                    CLK,
    input  wire logic                    RST,
    input  wire logic [dsr_pkg::ADDR_W-1:0] ADDR,
    input  wire logic [dsr_pkg::DATA_W-1:0] WDATA,
    input  wire logic                    WR,
    input  wire logic                    RD,
    output logic      [dsr_pkg::DATA_W-1:0] RDATA,
    input  wire logic [6:0]              DIE_TEMPERATURE_CODE,
    input  wire dsr_pkg::dsr_supply_t    SUPPLY_IN,
    input  wire dsr_pkg::dsr_func_t      FUNC_IN
);
    import dsr_pkg::*;

    logic [TEMP_W-1:0]        die_temperature_code_q;
    logic                     low_pump_undervolt_state_q;
    logic                     high_pump_undervolt_state_q;
    logic                     logic_reg_undervolt_state_q;
    logic                     logic_reg_overvolt_state_q;
    logic                     buck_supply_undervolt_state_q;
    logic                     buck_supply_overvolt_state_q;
    logic [SUPPLY_CODE_W-1:0] input_supply_code_q;
    logic [HALL_W-1:0]        hall_input_levels_q;
    logic                     hall_polarity_equal_q;
    logic                     hall_polarity_equal_d;
    logic                     logic_reg_setpoint_q;
    logic [GAIN_W-1:0]        sense_amp_gain_state_q;
    logic [DRAIN_SRC_W-1:0]   drain_src_state_q;

    logic [DATA_W-1:0]        temp_word;
    logic [DATA_W-1:0]        supply_word;
    logic [DATA_W-1:0]        func_word;

    logic [DATA_W-1:0]        rdata_d;
    logic [DATA_W-1:0]        rdata_q;
    logic                     unused_wr;

    // ****************************************************************
    // Write port
    // ****************************************************************
    // Writes have no effect on any status field.
    assign unused_wr = WR ^ (|WDATA);

    // ****************************************************************
    // Hall polarity comparison
    // ****************************************************************
    // All high and all low both count as equal polarity.
    // The result is registered like every other field.
    always_comb
    begin
        hall_polarity_equal_d = (&FUNC_IN.hall_input_levels) |
                                ~(|FUNC_IN.hall_input_levels);
    end

    // ****************************************************************
    // Die temperature code
    // ****************************************************************
    // Sampled on every edge so a read shows the live code.
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            die_temperature_code_q <= STATUS_RESET[TEMP_W-1:0];
        end
        else
        begin
            die_temperature_code_q <= DIE_TEMPERATURE_CODE;
        end
    end

    // ****************************************************************
    // Low-side pump undervoltage state
    // ****************************************************************
    // A one means the rail is above its threshold.
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            low_pump_undervolt_state_q <= STATUS_RESET[0];
        end
        else
        begin
            low_pump_undervolt_state_q <=
                SUPPLY_IN.low_pump_undervolt_state;
        end
    end

    // ****************************************************************
    // High-side pump undervoltage state
    // ****************************************************************
    // A one means the rail is above its threshold.
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            high_pump_undervolt_state_q <= STATUS_RESET[0];
        end
        else
        begin
            high_pump_undervolt_state_q <=
                SUPPLY_IN.high_pump_undervolt_state;
        end
    end

    // ****************************************************************
    // Logic regulator undervoltage state
    // ****************************************************************
    // A one means the regulator output is above its threshold.
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            logic_reg_undervolt_state_q <= STATUS_RESET[0];
        end
        else
        begin
            logic_reg_undervolt_state_q <=
                SUPPLY_IN.logic_reg_undervolt_state;
        end
    end

    // ****************************************************************
    // Logic regulator overvoltage state
    // ****************************************************************
    // A one means the regulator output is above its threshold.
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            logic_reg_overvolt_state_q <= STATUS_RESET[0];
        end
        else
        begin
            logic_reg_overvolt_state_q <=
                SUPPLY_IN.logic_reg_overvolt_state;
        end
    end

    // ****************************************************************
    // Buck supply undervoltage state
    // ****************************************************************
    // A one means the buck rail is above its threshold.
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            buck_supply_undervolt_state_q <= STATUS_RESET[0];
        end
        else
        begin
            buck_supply_undervolt_state_q <=
                SUPPLY_IN.buck_supply_undervolt_state;
        end
    end

    // ****************************************************************
    // Buck supply overvoltage state
    // ****************************************************************
    // A one means the buck rail is above its threshold.
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            buck_supply_overvolt_state_q <= STATUS_RESET[0];
        end
        else
        begin
            buck_supply_overvolt_state_q <=
                SUPPLY_IN.buck_supply_overvolt_state;
        end
    end

    // ****************************************************************
    // Input supply conversion result
    // ****************************************************************
    // Holds the latest conversion handed over by the converter.
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            input_supply_code_q <= STATUS_RESET[SUPPLY_CODE_W-1:0];
        end
        else
        begin
            input_supply_code_q <= SUPPLY_IN.input_supply_code;
        end
    end

    // ****************************************************************
    // Hall polarity equal flag
    // ****************************************************************
    // Follows the comparison on every edge, with no latching.
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            hall_polarity_equal_q <= STATUS_RESET[0];
        end
        else
        begin
            hall_polarity_equal_q <= hall_polarity_equal_d;
        end
    end

    // ****************************************************************
    // Logic regulator set point
    // ****************************************************************
    // Shows the active set point whatever chose it.
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            logic_reg_setpoint_q <= STATUS_RESET[0];
        end
        else
        begin
            logic_reg_setpoint_q <= FUNC_IN.logic_reg_setpoint;
        end
    end

    // ****************************************************************
    // Sense amplifier gain code
    // ****************************************************************
    // Shows the active gain code whatever chose it.
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            sense_amp_gain_state_q <= STATUS_RESET[GAIN_W-1:0];
        end
        else
        begin
            sense_amp_gain_state_q <= FUNC_IN.sense_amp_gain_state;
        end
    end

    // ****************************************************************
    // Hall input levels, one flip-flop per phase
    // ****************************************************************
    // Bit 0 is phase A, bit 2 is phase C.
    for (genvar p = 0; p < HALL_W; p++)
    begin : g_hall
        always_ff @(posedge CLK)
        begin
            if (RST)
            begin
                hall_input_levels_q[p] <= STATUS_RESET[0];
            end
            else
            begin
                hall_input_levels_q[p] <= FUNC_IN.hall_input_levels[p];
            end
        end
    end

    // ****************************************************************
    // Drain-source comparators, one flip-flop per switch
    // ****************************************************************
    // A one marks a comparator that sees a fault.
    for (genvar b = 0; b < DRAIN_SRC_W; b++)
    begin : g_drain_src
        always_ff @(posedge CLK)
        begin
            if (RST)
            begin
                drain_src_state_q[b] <= STATUS_RESET[0];
            end
            else
            begin
                drain_src_state_q[b] <= FUNC_IN.drain_src_state[b];
            end
        end
    end

    // ****************************************************************
    // Temperature register word
    // ****************************************************************
    // Reserved bits are tied to zero.
    always_comb
    begin
        temp_word = '0;
        temp_word[TEMP_LSB +: TEMP_W] = die_temperature_code_q;
    end

    // ****************************************************************
    // Supply status register word
    // ****************************************************************
    // Reserved bits are tied to zero.
    always_comb
    begin
        supply_word = '0;
        supply_word[LOW_PUMP_UV_BIT] = low_pump_undervolt_state_q;
        supply_word[HIGH_PUMP_UV_BIT] = high_pump_undervolt_state_q;
        supply_word[LOGIC_UV_BIT] = logic_reg_undervolt_state_q;
        supply_word[LOGIC_OV_BIT] = logic_reg_overvolt_state_q;
        supply_word[BUCK_UV_BIT] = buck_supply_undervolt_state_q;
        supply_word[BUCK_OV_BIT] = buck_supply_overvolt_state_q;
        supply_word[SUPPLY_CODE_LSB +: SUPPLY_CODE_W] = input_supply_code_q;
    end

    // ****************************************************************
    // Functional status register word
    // ****************************************************************
    // Reserved bits are tied to zero.
    always_comb
    begin
        func_word = '0;
        func_word[HALL_LSB +: HALL_W] = hall_input_levels_q;
        func_word[HALL_EQ_BIT] = hall_polarity_equal_q;
        func_word[SETPOINT_BIT] = logic_reg_setpoint_q;
        func_word[GAIN_LSB +: GAIN_W] = sense_amp_gain_state_q;
        func_word[DRAIN_SRC_LSB +: DRAIN_SRC_W] = drain_src_state_q;
    end

    // ****************************************************************
    // Read decode
    // ****************************************************************
    // Unmapped addresses read as zero.
    always_comb
    begin
        case (ADDR)
            TEMP_STATUS_OFS:   rdata_d = temp_word;
            SUPPLY_STATUS_OFS: rdata_d = supply_word;
            FUNC_STATUS_OFS:   rdata_d = func_word;
            default:           rdata_d = '0;
        endcase
    end

    // ****************************************************************
    // Read data register
    // ****************************************************************
    // Data stand for one cycle after the strobe and are zero otherwise.
    // That lets several slaves share one read bus through an OR.
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            rdata_q <= '0;
        end
        else if (RD)
        begin
            rdata_q <= rdata_d;
        end
        else
        begin
            rdata_q <= '0;
        end
    end

    assign RDATA = rdata_q;

endmodule
`default_nettype wire

// ---- hdl/dsr_pkg.sv ----
// Summary of operation
// - Die temperature in bits 6:0, 2 C steps
// - Code zero is -94 C, all ones 160 C
// - Reserved status bits always read as zero
// - Pump undervoltage states in supply bits 0, 1
// - Logic regulator under/over states in bits 2, 3
// - Buck supply under/over states in bits 4, 5
// - Input supply conversion result in bits 12:6
// - Hall input levels mirrored in bits 2:0
// - Bit 3 set when all Hall inputs equal
// - Bit 4 shows logic regulator set point
// - Bits 7:5 show active sense gain code
// - Drain-source comparators in bits 8 to 13
// - Reset clears all three registers to zero
package dsr_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int          ADDR_W           = 8;
    localparam int          DATA_W           = 16;
    localparam logic [7:0]  TEMP_STATUS_OFS  = 8'h01;
    localparam logic [7:0]  SUPPLY_STATUS_OFS = 8'h02;
    localparam logic [7:0]  FUNC_STATUS_OFS  = 8'h03;
    localparam logic [15:0] STATUS_RESET     = 16'h0000;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int TEMP_LSB        = 0;
    localparam int TEMP_W          = 7;
    localparam int LOW_PUMP_UV_BIT = 0;
    localparam int HIGH_PUMP_UV_BIT = 1;
    localparam int LOGIC_UV_BIT    = 2;
    localparam int LOGIC_OV_BIT    = 3;
    localparam int BUCK_UV_BIT     = 4;
    localparam int BUCK_OV_BIT     = 5;
    localparam int SUPPLY_CODE_LSB = 6;
    localparam int SUPPLY_CODE_W   = 7;
    localparam int HALL_LSB        = 0;
    localparam int HALL_W          = 3;
    localparam int HALL_EQ_BIT     = 3;
    localparam int SETPOINT_BIT    = 4;
    localparam int GAIN_LSB        = 5;
    localparam int GAIN_W          = 3;
    localparam int DRAIN_SRC_LSB   = 8;
    localparam int DRAIN_SRC_W     = 6;

    // Temperature code scale in degrees Celsius.
    localparam int TEMP_ZERO_DEGC  = -94;
    localparam int TEMP_FULL_DEGC  = 160;
    localparam int TEMP_STEP_DEGC  = 2;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic       low_pump_undervolt_state;
        logic       high_pump_undervolt_state;
        logic       logic_reg_undervolt_state;
        logic       logic_reg_overvolt_state;
        logic       buck_supply_undervolt_state;
        logic       buck_supply_overvolt_state;
        logic [6:0] input_supply_code;
    } dsr_supply_t;

    // Drain-source order, bit 0 first: high a, low a, high b, low b,
    // high c, low c.
    typedef struct packed {
        logic [2:0] hall_input_levels;
        logic       logic_reg_setpoint;
        logic [2:0] sense_amp_gain_state;
        logic [5:0] drain_src_state;
    } dsr_func_t;

endpackage

// ---- dv/dsr_status_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module dsr_status_sva
(
    input wire logic                         CLK,
    input wire logic                         RST,
    input wire logic [dsr_pkg::ADDR_W-1:0]   ADDR,
    input wire logic [dsr_pkg::DATA_W-1:0]   WDATA,
    input wire logic                         WR,
    input wire logic                         RD,
    input wire logic [dsr_pkg::DATA_W-1:0]   RDATA,
    input wire logic [6:0]                   DIE_TEMPERATURE_CODE,
    input wire dsr_pkg::dsr_supply_t         SUPPLY_IN,
    input wire dsr_pkg::dsr_func_t           FUNC_IN
);
    import dsr_pkg::*;
    wire logic [32:0] in_w = {DIE_TEMPERATURE_CODE, SUPPLY_IN, FUNC_IN};
    logic [32:0]      in_q;
    logic             rst_q;
    logic             ok;
    always_ff @(posedge CLK)
    begin
        in_q <= in_w;
        rst_q <= RST;
    end
    assign ok = RD && in_w == in_q && !rst_q;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    a_temp_value: assert property (ok && ADDR == 8'h01 |=>
        RDATA[6:0] == in_q[32:26]) else $error("temp code");
    a_temp_resv: assert property (RD && ADDR == 8'h01 |=>
        RDATA[15:7] == 9'h000) else $error("temp reserved");
    a_supply_mons: assert property (ok && ADDR == 8'h02 |=>
        RDATA[5:0] == {<<{in_q[25:20]}}) else $error("monitor bits");
    a_supply_code: assert property (ok && ADDR == 8'h02 |=>
        RDATA[15:6] == {3'h0, in_q[19:13]}) else $error("supply code");
    a_hall_equal: assert property (ok && ADDR == 8'h03 |=>
        RDATA[3] == (in_q[12:10] inside {3'h0, 3'h7})) else $error("hall eq");
    a_func_fields: assert property (ok && ADDR == 8'h03 |=>
        {RDATA[15:4], RDATA[2:0]} ==
        {2'h0, in_q[5:0], in_q[8:6], in_q[9], in_q[12:10]})
        else $error("func fields");
    a_unmapped_zero: assert property (RD && !(ADDR inside {[8'h01:8'h03]})
        |=> RDATA == 16'h0000) else $error("unmapped read");
    a_idle_zero: assert property (!RD |=> RDATA == 16'h0000)
        else $error("idle data");
    a_reset_zero: assert property (RD && rst_q |=> RDATA == 16'h0000)
        else $error("reset value");
    c_hall_same: cover property (ok && ADDR == 8'h03 && in_w[12:10] == 3'h7);
    c_write: cover property (WR);
    c_boot_read: cover property (RD && rst_q);
endmodule
`default_nettype wire

// ---- dv/dsr_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module dsr_host
(
    input  wire logic        clk,
    output logic [7:0]       addr,
    output logic [15:0]      wdata,
    output logic             wr,
    output logic             rd
);
    initial
    begin
        {addr, wdata, wr, rd} = '0;
    end
    // Released address and data lines show the inverse of the last value; wr and rd drop to zero.
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [15:0] d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask
endmodule
`default_nettype wire

// ---- dv/test_driver_status_registers.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_driver_status_registers;
    import dsr_pkg::*;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic [6:0] temp = 7'h7F;
    dsr_supply_t sup = 13'h1FFF;
    dsr_func_t fun = 13'h1FFF;
    logic [7:0] addr;
    logic [15:0] wdata, rdata, e_q[$];
    logic wr, rd, seen = 1'b0;
    logic [63:0] r;
    logic [5:0] mon;
    int failures = 0, check_count = 0, cyc = 0;
    always #25 CLK = ~CLK;
    dsr_host host(.clk(CLK), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
    dsr_status_regs uut(.CLK(CLK), .RST(RST), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .DIE_TEMPERATURE_CODE(temp),
        .SUPPLY_IN(sup), .FUNC_IN(fun));
    task automatic finish_test;
        if (failures == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic rd_exp(input logic [7:0] a, input logic [15:0] e);
        e_q.push_back(e);
        host.acc(1'b0, a, 16'h0000);
    endtask
    always @(posedge CLK)
    begin
        cyc++;
        if (cyc > 2000)
            failures++;
        if (cyc > 2000)
            finish_test();
        if (seen && rdata !== e_q[0])
            $display("BAD rdata exp %h got %h", e_q[0], rdata);
        failures += int'(seen && rdata !== e_q[0]);
        check_count += int'(seen);
        if (seen)
            e_q.delete(0);
        seen = rd;
    end
    initial
    begin
        void'($urandom(52));
        repeat (5) @(posedge CLK);
        fork
            RST <= @(posedge CLK) 1'b0;
            rd_exp(8'h01, 16'h0000);
        join
        for (int i = 0; i < 40; i++)
        begin
            r = {$urandom, $urandom};
            @(posedge CLK);
            temp <= r[6:0];
            sup <= r[19:7];
            fun <= (i < 8) ? {3'(i), r[29], 3'(i), r[25:20]} : r[32:20];
            #1;
            mon = {<<{sup[12:7]}};
            host.acc(1'b1, {6'h00, r[34:33]}, r[63:48]);
            rd_exp(8'h01, {9'h000, temp});
            rd_exp(8'h02, {3'h0, sup.input_supply_code, mon});
            rd_exp(8'h03, {2'h0, fun[5:0], fun[8:6], fun[9],
                (fun[12:10] inside {3'h0, 3'h7}), fun[12:10]});
            rd_exp({r[47:42], 2'h0}, 16'h0000);
        end
        repeat (3) @(posedge CLK);
        finish_test();
    end
endmodule
bind dsr_status_regs dsr_status_sva chk(.CLK(CLK), .RST(RST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SUPPLY_IN(SUPPLY_IN),
    .DIE_TEMPERATURE_CODE(DIE_TEMPERATURE_CODE), .FUNC_IN(FUNC_IN));
`default_nettype wire
